// >>> verilog/grcp_map.vh
// Constants for the report command parser: sub-codes, report lengths, field offsets, defaults.
// Assumes a packet framing layer outside that delivers de-stuffed payload bytes with start/end marks.
`ifndef GRCP_MAP_VH
`define GRCP_MAP_VH

`define GRCP_CMD_COMPACT 8'h23
`define GRCP_CMD_SAVE 8'h26
`define GRCP_CMD_CONFIG 8'h40
`define GRCP_CMD_FIXQ 8'h37
`define GRCP_COMPACT_LEN 6'h1d
`define GRCP_SAVE_LEN 6'h05
`define GRCP_CONFIG_LEN 6'h0b
`define GRCP_CONFIG_SET_LEN 6'h0b
`define GRCP_FLAGS_RST 8'h0e
`define GRCP_FLAGS_MASK 8'h1f
`define GRCP_HB_SENT_RST 8'h0b
`define GRCP_TOH_RST 16'h0000
`define GRCP_HB_RST 16'h0005
`define GRCP_LIMIT_MAX 16'h0e0f
`define GRCP_VEH_RST 32'h30303030
`define GRCP_ST_FIX_NONE 0
`define GRCP_ST_VSCALE 5
`define GRCP_ST_EPH 6
`define GRCP_ST_ALM 7

`endif

// >>> verilog/grcp_cmd_rx.v
// Command byte collector: holds up to eleven payload bytes of one packet and counts them.
// Assumes the framing layer marks the first byte with start and the last with end.
`include "grcp_map.vh"

module grcp_cmd_rx
(
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Payload in
  input wire in_valid,
  input wire [7:0] in_byte,
  input wire in_start,
  input wire in_end,
  input wire accept,
  // Collected packet
  output reg pkt_done_r,
  output reg [5:0] pkt_len_r,
  output reg [87:0] pkt_bytes_r
);

  reg [5:0] cnt_r;

  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      cnt_r <= 6'h00;
      pkt_len_r <= 6'h00;
      pkt_bytes_r <= 88'h0;
      pkt_done_r <= 1'b0;
    end
    else
    begin
      pkt_done_r <= 1'b0;
      if (in_valid && accept)
      begin
        // Bytes beyond eleven are counted but dropped; the length then marks the packet invalid.
        if (in_start)
        begin
          pkt_bytes_r <= {80'h0, in_byte};
          cnt_r <= 6'h01;
        end
        else if (cnt_r < 6'h0b)
        begin
          pkt_bytes_r[cnt_r*8 +: 8] <= in_byte;
          cnt_r <= cnt_r + 6'h01;
        end
        else if (cnt_r != 6'h3f)
        begin
          cnt_r <= cnt_r + 6'h01;
        end
        if (in_end)
        begin
          pkt_done_r <= 1'b1;
          pkt_len_r <= in_start ? 6'h01 : cnt_r + 6'h01;
        end
      end
    end
  end

endmodule // grcp_cmd_rx

// >>> verilog/grcp_tx_ser.v
// Report serializer: sends a byte image of given length, lowest byte first, under ready back-pressure.
// Assumes the image stays stable from load until busy falls.
`include "grcp_map.vh"

module grcp_tx_ser
(
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Load
  input wire load,
  input wire [5:0] load_len,
  input wire [231:0] image,
  output wire busy,
  // Byte stream out
  output wire out_valid,
  output reg [7:0] out_byte_r,
  output reg out_last_r,
  input wire out_ready
);

  reg [5:0] idx_r;
  reg [5:0] len_r;
  reg act_r;

  assign busy = act_r;
  assign out_valid = act_r;

  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      idx_r <= 6'h00;
      len_r <= 6'h00;
      act_r <= 1'b0;
      out_byte_r <= 8'h00;
      out_last_r <= 1'b0;
    end
    else if (load && !act_r)
    begin
      act_r <= 1'b1;
      len_r <= load_len;
      idx_r <= 6'h01;
      out_byte_r <= image[7:0];
      out_last_r <= (load_len == 6'h01);
    end
    else if (act_r && out_ready)
    begin
      if (out_last_r)
      begin
        act_r <= 1'b0;
        out_last_r <= 1'b0;
      end
      else
      begin
        out_byte_r <= image[idx_r*8 +: 8];
        out_last_r <= (idx_r + 6'h01 == len_r);
        idx_r <= idx_r + 6'h01;
      end
    end
  end

endmodule // grcp_tx_ser

// >>> verilog/grcp_parser.v
// Top of the report command parser: decodes commands, holds settings, builds and sends reports.
// Assumes the fix data inputs come from same-clock logic and stay valid while fix_update is low.
`include "grcp_map.vh"

module grcp_parser
(
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Command payload from framing layer
  input wire cmd_valid,
  input wire [7:0] cmd_byte,
  input wire cmd_start,
  input wire cmd_end,
  output wire cmd_ready,
  // Report payload to framing layer
  output wire rpt_valid,
  output wire [7:0] rpt_byte,
  output wire rpt_last,
  input wire rpt_ready,
  // Latest fix from navigation logic
  input wire fix_update,
  input wire [31:0] fix_tow_ms,
  input wire [15:0] fix_week,
  input wire [7:0] fix_leap_s,
  input wire fix_none,
  input wire fix_diff_corrected,
  input wire fix_2d,
  input wire fix_alt_user,
  input wire fix_filtered,
  input wire fix_vel_x4,
  input wire fix_eph_new,
  input wire fix_alm_good,
  input wire [31:0] fix_lat,
  input wire [31:0] fix_lon,
  input wire [31:0] fix_alt_mm,
  input wire [15:0] fix_vel_e,
  input wire [15:0] fix_vel_n,
  input wire [15:0] fix_vel_u,
  // Superpacket output enable, set by the output-options command elsewhere
  input wire super_out_en,
  // Nonvolatile memory write handshake
  output reg nv_write_r,
  output reg [87:0] nv_data_r,
  input wire nv_done,
  // Settings and status
  output reg compact_armed_r,
  output reg [7:0] cfg_flags_r,
  output reg [7:0] cfg_hb_sentence_r,
  output reg [15:0] cfg_toh_offset_r,
  output reg [15:0] cfg_hb_interval_r,
  output reg [31:0] cfg_vehicle_label_r,
  output reg cmd_bad_r
);

  // ****
  // State codes and storage
  // ****
  localparam ST_IDLE = 2'd0;
  localparam ST_NVWAIT = 2'd1;
  localparam ST_SEND = 2'd2;

  reg [1:0] state_r;
  reg [231:0] img_r;
  reg [5:0] img_len_r;
  reg load_r;
  reg auto_pend_r;
  wire pkt_done;
  wire [5:0] pkt_len;
  wire [87:0] pkt;
  wire ser_busy;

  // ****
  // Field helpers
  // ****
  // Byte n of a packet image.
  function [7:0] pbyte;
    input [87:0] b;
    input [3:0] n;
    begin
      pbyte = b[n*8 +: 8];
    end
  endfunction

  // Big-endian 16-bit field from two payload bytes.
  function [15:0] be16;
    input [7:0] hi;
    input [7:0] lo;
    begin
      be16 = {hi, lo};
    end
  endfunction

  // Heartbeat sentence codes that the automatic output knows; any other would leave it silent.
  function sentence_known;
    input [7:0] code;
    begin
      case (code)
        8'h00, 8'h02, 8'h06, 8'h08, 8'h0b, 8'h0e, 8'h0f, 8'h10:
          sentence_known = 1'b1;
        default:
          sentence_known = 1'b0;
      endcase
    end
  endfunction

  // ****
  // Byte collector and serializer
  // ****
  // Commands are taken only while idle; a packet in flight holds the link off.
  assign cmd_ready = (state_r == ST_IDLE) && !load_r;

  grcp_cmd_rx u_rx
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_valid(cmd_valid),
    .in_byte(cmd_byte),
    .in_start(cmd_start),
    .in_end(cmd_end),
    .accept(cmd_ready),
    .pkt_done_r(pkt_done),
    .pkt_len_r(pkt_len),
    .pkt_bytes_r(pkt)
  );

  grcp_tx_ser u_tx
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .load(load_r),
    .load_len(img_len_r),
    .image(img_r),
    .busy(ser_busy),
    .out_valid(rpt_valid),
    .out_byte_r(rpt_byte),
    .out_last_r(rpt_last),
    .out_ready(rpt_ready)
  );

  // ****
  // Report images
  // ****
  // Compact report image: fields are most significant byte first, byte 0 lowest.
  wire [7:0] status_byte;
  assign status_byte = {fix_alm_good, fix_eph_new, fix_vel_x4, fix_filtered,
                        fix_alt_user, fix_2d, fix_diff_corrected, fix_none};
  wire [231:0] compact_img;
  assign compact_img = {
    16'h0000,
    fix_vel_u[7:0], fix_vel_u[15:8],
    fix_vel_n[7:0], fix_vel_n[15:8],
    fix_vel_e[7:0], fix_vel_e[15:8],
    fix_alt_mm[7:0], fix_alt_mm[15:8], fix_alt_mm[23:16], fix_alt_mm[31:24],
    fix_lon[7:0], fix_lon[15:8], fix_lon[23:16], fix_lon[31:24],
    fix_lat[7:0], fix_lat[15:8], fix_lat[23:16], fix_lat[31:24],
    status_byte,
    fix_leap_s,
    fix_week[7:0], fix_week[15:8],
    fix_tow_ms[7:0], fix_tow_ms[15:8], fix_tow_ms[23:16], fix_tow_ms[31:24],
    `GRCP_CMD_COMPACT};

  wire [87:0] cfg_img;
  assign cfg_img = {cfg_vehicle_label_r[7:0], cfg_vehicle_label_r[15:8],
                    cfg_vehicle_label_r[23:16], cfg_vehicle_label_r[31:24],
                    cfg_hb_interval_r[7:0], cfg_hb_interval_r[15:8],
                    cfg_toh_offset_r[7:0], cfg_toh_offset_r[15:8],
                    cfg_hb_sentence_r, cfg_flags_r, `GRCP_CMD_CONFIG};

  // The save status carries its sub-code and four reserved bytes sent as zero.
  wire [231:0] save_img;
  assign save_img = {192'h0, 32'h0, `GRCP_CMD_SAVE};
  // A set is answered with what it stored, so the reserved flag bits read back as zero.
  wire [231:0] set_echo_img;
  assign set_echo_img = {144'h0, pkt[87:8] & 80'hffffffffffffffffff1f, `GRCP_CMD_CONFIG};

  // ****
  // Settings set form
  // ****
  wire [15:0] set_toh;
  wire [15:0] set_hb;
  wire set_ok;
  assign set_toh = be16(pbyte(pkt, 4'd3), pbyte(pkt, 4'd4));
  assign set_hb = be16(pbyte(pkt, 4'd5), pbyte(pkt, 4'd6));
  // Out-of-range times or an unknown sentence code make the whole set invalid rather than clamping.
  assign set_ok = (set_toh <= `GRCP_LIMIT_MAX) && (set_hb <= `GRCP_LIMIT_MAX) &&
                  sentence_known(pbyte(pkt, 4'd2));

  wire [7:0] sub;
  assign sub = pbyte(pkt, 4'd0);

  // ****
  // Command decode
  // ****
  // A packet of the sub-code alone is the bare form of every command handled here.
  // Anything that fits no form, a wrong length included, is answered by a one-cycle cmd_bad_r if pkt_done finds the sequencer still in ST_IDLE.
  wire bare;
  wire is_fix_req;
  wire is_arm_ctl;
  wire is_fix_query;
  wire is_save_req;
  wire is_cfg_query;
  wire is_cfg_set;
  assign bare = (pkt_len == 6'h01);
  assign is_fix_req = (sub == `GRCP_CMD_COMPACT) && bare;
  assign is_arm_ctl = (sub == `GRCP_CMD_COMPACT) && (pkt_len == 6'h02) && (pbyte(pkt, 4'd1) <= 8'h01);
  // The fix query is refused while the compact report is not armed.
  assign is_fix_query = (sub == `GRCP_CMD_FIXQ) && bare && compact_armed_r;
  assign is_save_req = (sub == `GRCP_CMD_SAVE) && bare;
  assign is_cfg_query = (sub == `GRCP_CMD_CONFIG) && bare;
  assign is_cfg_set = (sub == `GRCP_CMD_CONFIG) && (pkt_len == `GRCP_CONFIG_SET_LEN) && set_ok;

  // ****
  // Automatic report request
  // ****
  // A fix landing in the cycle a waiting report is taken queues the next one, so the set wins.
  // Dropping the arm or the superpacket enable withdraws a waiting report, since output needs both.
  wire auto_take;
  assign auto_take = (state_r == ST_IDLE) && !pkt_done && !load_r && auto_pend_r &&
                     compact_armed_r && super_out_en;
  always @(posedge clk_sys)
  begin
    if (!resetn)
      auto_pend_r <= 1'b0;
    else if (fix_update && compact_armed_r && super_out_en)
      auto_pend_r <= 1'b1;
    else if (auto_take || !compact_armed_r || !super_out_en)
      auto_pend_r <= 1'b0;
  end

  // ****
  // Main sequencer
  // ****
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      img_r <= 232'h0;
      img_len_r <= 6'h00;
      load_r <= 1'b0;
      nv_write_r <= 1'b0;
      nv_data_r <= 88'h0;
      compact_armed_r <= 1'b0;
      cfg_flags_r <= `GRCP_FLAGS_RST;
      cfg_hb_sentence_r <= `GRCP_HB_SENT_RST;
      cfg_toh_offset_r <= `GRCP_TOH_RST;
      cfg_hb_interval_r <= `GRCP_HB_RST;
      cfg_vehicle_label_r <= `GRCP_VEH_RST;
      cmd_bad_r <= 1'b0;
    end
    else
    begin
      load_r <= 1'b0;
      nv_write_r <= 1'b0;
      cmd_bad_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (pkt_done && !load_r)
          begin
            if (is_fix_req)
            begin
              img_r <= compact_img;
              img_len_r <= `GRCP_COMPACT_LEN;
              load_r <= 1'b1;
              state_r <= ST_SEND;
            end
            else if (is_arm_ctl)
            begin
              compact_armed_r <= pbyte(pkt, 4'd1) == 8'h01;
            end
            else if (is_fix_query)
            begin
              img_r <= compact_img;
              img_len_r <= `GRCP_COMPACT_LEN;
              load_r <= 1'b1;
              state_r <= ST_SEND;
            end
            else if (is_save_req)
            begin
              nv_data_r <= cfg_img;
              nv_write_r <= 1'b1;
              state_r <= ST_NVWAIT;
            end
            else if (is_cfg_query)
            begin
              img_r <= {144'h0, cfg_img};
              img_len_r <= `GRCP_CONFIG_LEN;
              load_r <= 1'b1;
              state_r <= ST_SEND;
            end
            else if (is_cfg_set)
            begin
              cfg_flags_r <= pbyte(pkt, 4'd1) & `GRCP_FLAGS_MASK;
              cfg_hb_sentence_r <= pbyte(pkt, 4'd2);
              cfg_toh_offset_r <= set_toh;
              cfg_hb_interval_r <= set_hb;
              cfg_vehicle_label_r <= {pbyte(pkt, 4'd7), pbyte(pkt, 4'd8),
                                      pbyte(pkt, 4'd9), pbyte(pkt, 4'd10)};
              img_r <= set_echo_img;
              img_len_r <= `GRCP_CONFIG_LEN;
              load_r <= 1'b1;
              state_r <= ST_SEND;
            end
            else
              cmd_bad_r <= 1'b1;
          end
          else if (auto_take)
          begin
            img_r <= compact_img;
            img_len_r <= `GRCP_COMPACT_LEN;
            load_r <= 1'b1;
            state_r <= ST_SEND;
          end
        end
        ST_NVWAIT:
        begin
          // The status report waits for the memory to finish, however long it takes.
          if (nv_done)
          begin
            img_r <= save_img;
            img_len_r <= `GRCP_SAVE_LEN;
            load_r <= 1'b1;
            state_r <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          // load_r covers the one cycle before the serializer shows busy.
          if (!load_r && !ser_busy)
            state_r <= ST_IDLE;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

endmodule // grcp_parser

// >>> tb/grcp_assertions.sv
// Concurrent checks on the ports of the report command parser.
// Assumes one clock and the synchronous active-low reset of the parser.
module grcp_assertions (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Streams
  input wire cmd_ready,
  input wire rpt_valid,
  input wire [7:0] rpt_byte,
  input wire rpt_last,
  input wire rpt_ready,
  // Save and settings
  input wire nv_write_r,
  input wire [87:0] nv_data_r,
  input wire nv_done,
  input wire [15:0] cfg_toh_offset_r,
  input wire [15:0] cfg_hb_interval_r,
  input wire cmd_bad_r
);
  // ****
  // Byte position tracking
  // ****
  logic [4:0] cnt_r;
  logic [7:0] id_r;
  logic nv_wait_r;
  wire [7:0] id = (cnt_r == 5'h00) ? rpt_byte : id_r;
  wire [4:0] last_idx = (id == 8'h23) ? 5'h1c : ((id == 8'h26) ? 5'h04 : 5'h0a);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  always @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      cnt_r <= 5'h00;
      id_r <= 8'h00;
      nv_wait_r <= 1'b0;
    end
    else
    begin
      if (rpt_valid && rpt_ready)
        cnt_r <= rpt_last ? 5'h00 : cnt_r + 5'h01;
      if (rpt_valid && rpt_ready && cnt_r == 5'h00)
        id_r <= rpt_byte;
      if (nv_write_r)
        nv_wait_r <= 1'b1;
      else if (nv_done)
        nv_wait_r <= 1'b0;
    end
  end
  AST_HOLD: assert property (rpt_valid && !rpt_ready |=>
    rpt_valid && $stable(rpt_byte) && $stable(rpt_last)) else $error("report byte dropped before accept");
  AST_SUBCODE: assert property (rpt_valid && cnt_r == 5'h00 |->
    rpt_byte == 8'h23 || rpt_byte == 8'h26 || rpt_byte == 8'h40) else $error("bad report sub-code");
  AST_LEN: assert property (rpt_valid && rpt_last |-> cnt_r == last_idx)
    else $error("report length wrong");
  AST_TAIL: assert property (rpt_valid && id == 8'h23 && cnt_r >= 5'h1b |-> rpt_byte == 8'h00)
    else $error("compact flag bytes not zero");
  AST_SAVE_RSV: assert property (rpt_valid && id == 8'h26 && cnt_r != 5'h00 |-> rpt_byte == 8'h00)
    else $error("save report reserved byte not zero");
  AST_FLAG_RSV: assert property (rpt_valid && id == 8'h40 && cnt_r == 5'h01 |-> rpt_byte[7:5] == 3'h0)
    else $error("reserved flag bits sent");
  AST_NV_FIRST: assert property (nv_wait_r |-> !rpt_valid)
    else $error("report before store finished");
  AST_NV_ANSWER: assert property (nv_wait_r && nv_done |-> ##[1:4] (rpt_valid && rpt_byte == 8'h26))
    else $error("no save report after store");
  AST_NV_IMG: assert property (nv_write_r |-> nv_data_r[7:0] == 8'h40)
    else $error("store image header wrong");
  AST_CFG_RANGE: assert property (cfg_toh_offset_r <= 16'h0e0f && cfg_hb_interval_r <= 16'h0e0f)
    else $error("setting out of range");
  AST_BUSY: assert property (rpt_valid |-> !cmd_ready)
    else $error("command taken during report");
  cover property (rpt_valid && rpt_ready && rpt_last && id_r == 8'h23);
  cover property (nv_wait_r && nv_done);
  cover property (cmd_bad_r);
endmodule // grcp_assertions

bind grcp_parser grcp_assertions grcp_assertions_inst (.clk_sys(clk_sys), .resetn(resetn), .cmd_ready(cmd_ready),
  .rpt_valid(rpt_valid), .rpt_byte(rpt_byte), .rpt_last(rpt_last), .rpt_ready(rpt_ready), .nv_write_r(nv_write_r),
  .nv_data_r(nv_data_r), .nv_done(nv_done), .cfg_toh_offset_r(cfg_toh_offset_r),
  .cfg_hb_interval_r(cfg_hb_interval_r), .cmd_bad_r(cmd_bad_r));

// >>> tb/grcp_host_model.sv
// Host side model: accepts report bytes with mixed stalls and acts as the settings store.
// Assumes the bench reads and clears the collected bytes between reports.
module grcp_host_model (
  // Clock
  input wire logic clk_sys,
  // Report stream
  input wire logic rpt_valid,
  input wire logic [7:0] rpt_byte,
  input wire logic rpt_last,
  output logic rpt_ready,
  // Settings store
  input wire logic nv_write_r,
  output logic nv_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic [31:0] sd = 32'h523e2398;
  int nvw = 0;
  initial
  begin
    rpt_ready = 1'b0;
    nv_done = 1'b0;
  end
  always @(posedge clk_sys)
  begin
    if (rpt_valid === 1'b1 && rpt_ready)
      got.push_back(rpt_byte);
    if (nv_write_r === 1'b1)
      nvw = 5;
    else if (nvw > 0)
      nvw--;
  end
  // A slow store makes sure the report really waits for the write.
  always @(negedge clk_sys)
  begin
    sd = {sd[30:0], sd[31] ^ sd[21] ^ sd[1] ^ sd[0]};
    rpt_ready <= sd[3] | sd[6];
    nv_done <= (nvw == 1);
  end
endmodule // grcp_host_model

// >>> tb/tb_top.sv
// Self-checking bench for the report command parser against a queue model.
// Assumes grcp_host_model consumes reports and answers store writes.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0, cmd_start = 1'b0, cmd_end = 1'b0, fix_update = 1'b0, super_out_en = 1'b0;
  logic [7:0] cmd_byte = '0, fix_leap_s = '0, st = '0, m_flags = 8'h0e, m_sent = 8'h0b, cmd[$], exp[$];
  logic [31:0] fix_tow_ms = '0, fix_lat = '0, fix_lon = '0, fix_alt_mm = '0, m_vl = 32'h30303030, lf = 32'h523e2398;
  logic [15:0] fix_week = '0, fix_vel_e = '0, fix_vel_n = '0, fix_vel_u = '0, m_toh = 16'h0000, m_hb = 16'h0005;
  logic [7:0] codes[8] = '{8'h00, 8'h02, 8'h06, 8'h08, 8'h0b, 8'h0e, 8'h0f, 8'h10};
  logic [87:0] nv_img = '0;
  wire cmd_ready, rpt_valid, rpt_last, rpt_ready, nv_write_r, nv_done, compact_armed_r, cmd_bad_r;
  wire [7:0] rpt_byte, cfg_flags_r, cfg_hb_sentence_r;
  wire [15:0] cfg_toh_offset_r, cfg_hb_interval_r;
  wire [31:0] cfg_vehicle_label_r;
  wire [87:0] nv_data_r;
  int error_cnt = 0, checked = 0, bad_cnt = 0, k;
  grcp_parser grcp_parser_inst (.clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .cmd_start(cmd_start), .cmd_end(cmd_end), .cmd_ready(cmd_ready), .rpt_valid(rpt_valid), .rpt_byte(rpt_byte),
    .rpt_last(rpt_last), .rpt_ready(rpt_ready), .fix_update(fix_update), .fix_tow_ms(fix_tow_ms),
    .fix_week(fix_week), .fix_leap_s(fix_leap_s), .fix_none(st[0]), .fix_diff_corrected(st[1]), .fix_2d(st[2]),
    .fix_alt_user(st[3]), .fix_filtered(st[4]), .fix_vel_x4(st[5]), .fix_eph_new(st[6]), .fix_alm_good(st[7]),
    .fix_lat(fix_lat), .fix_lon(fix_lon), .fix_alt_mm(fix_alt_mm), .fix_vel_e(fix_vel_e), .fix_vel_n(fix_vel_n),
    .fix_vel_u(fix_vel_u), .super_out_en(super_out_en), .nv_write_r(nv_write_r), .nv_data_r(nv_data_r),
    .nv_done(nv_done), .compact_armed_r(compact_armed_r), .cfg_flags_r(cfg_flags_r),
    .cfg_hb_sentence_r(cfg_hb_sentence_r), .cfg_toh_offset_r(cfg_toh_offset_r),
    .cfg_hb_interval_r(cfg_hb_interval_r), .cfg_vehicle_label_r(cfg_vehicle_label_r), .cmd_bad_r(cmd_bad_r));
  grcp_host_model grcp_host_model_inst (.clk_sys(clk_sys), .rpt_valid(rpt_valid), .rpt_byte(rpt_byte),
    .rpt_last(rpt_last), .rpt_ready(rpt_ready), .nv_write_r(nv_write_r), .nv_done(nv_done));
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    if (nv_write_r === 1'b1)
      nv_img <= nv_data_r;
    if (cmd_bad_r === 1'b1)
      bad_cnt++;
  end
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  task automatic close_out();
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rpt(input string nm);
    chk_val(nm, exp.size(), grcp_host_model_inst.got.size());
    for (int j = 0; j < exp.size() && j < grcp_host_model_inst.got.size(); j++)
      chk_val(nm, exp[j], grcp_host_model_inst.got[j]);
    exp.delete();
    grcp_host_model_inst.got.delete();
  endtask
  task automatic exp_img(input logic [231:0] img, input int n);
    for (int j = n - 1; j >= 0; j--)
      exp.push_back(img[8 * j +: 8]);
  endtask
  task automatic exp_fix();
    exp_img({8'h23, fix_tow_ms, fix_week, fix_leap_s, st, fix_lat, fix_lon, fix_alt_mm, fix_vel_e, fix_vel_n,
      fix_vel_u, 16'h0000}, 29);
  endtask
  task automatic exp_cfg();
    exp_img({144'h0, 8'h40, m_flags & 8'h1f, m_sent, m_toh, m_hb, m_vl}, 11);
  endtask
  task automatic new_fix();
    fix_tow_ms = rnd();
    fix_week = 16'(rnd());
    fix_leap_s = 8'(rnd());
    st = 8'(rnd());
    fix_lat = rnd();
    fix_lon = rnd();
    fix_alt_mm = rnd();
    fix_vel_e = 16'(rnd());
    fix_vel_n = 16'(rnd());
    fix_vel_u = 16'(rnd());
  endtask
  // Waits until the parser takes commands again and no report is in flight.
  task automatic settle();
    int n = 0;
    repeat (6) @(negedge clk_sys);
    while (!(cmd_ready === 1'b1 && rpt_valid === 1'b0) && n < 500)
    begin
      n++;
      @(negedge clk_sys);
    end
    if (n == 500)
    begin
      error_cnt++;
      close_out();
    end
  endtask
  task automatic send();
    int n;
    foreach (cmd[j])
    begin
      cmd_valid = 1'b1;
      cmd_byte = cmd[j];
      cmd_start = (j == 0);
      cmd_end = (j == cmd.size() - 1);
      n = 0;
      while (cmd_ready !== 1'b1 && n < 500)
      begin
        n++;
        @(negedge clk_sys);
      end
      if (n == 500)
      begin
        error_cnt++;
        close_out();
      end
      @(negedge clk_sys);
    end
    cmd_valid = 1'b0;
    cmd_start = 1'b0;
    cmd_end = 1'b0;
    settle();
  endtask
  // ****
  // Scenarios
  // ****
  initial
  begin
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    chk_val("flags", m_flags, cfg_flags_r);
    chk_val("sentence", m_sent, cfg_hb_sentence_r);
    chk_val("interval", m_hb, cfg_hb_interval_r);
    chk_val("offset", m_toh, cfg_toh_offset_r);
    chk_val("label", m_vl, cfg_vehicle_label_r);
    chk_val("armed", 1'b0, compact_armed_r);
    for (k = 0; k < 4; k++)
    begin
      new_fix();
      cmd = {8'h23};
      send();
      exp_fix();
      chk_rpt("compact");
    end
    cmd = {8'h23, 8'h01};
    send();
    chk_val("armed", 1'b1, compact_armed_r);
    chk_rpt("arm");
    new_fix();
    cmd = {8'h37};
    send();
    exp_fix();
    chk_rpt("fix query");
    // The fix pulse with output disabled must leave nothing queued.
    for (k = 0; k < 2; k++)
    begin
      super_out_en = k[0];
      new_fix();
      fix_update = 1'b1;
      @(negedge clk_sys);
      fix_update = 1'b0;
      settle();
      if (k == 1)
        exp_fix();
      chk_rpt("auto");
    end
    cmd = {8'h23, 8'h00};
    send();
    chk_val("armed", 1'b0, compact_armed_r);
    k = bad_cnt;
    cmd = {8'h37};
    send();
    cmd = {8'h23, 8'h02};
    send();
    chk_val("refused", k + 2, bad_cnt);
    chk_rpt("refused");
    cmd = {8'h40};
    send();
    exp_cfg();
    chk_rpt("cfg query");
    for (k = 0; k < 8; k++)
    begin
      m_flags = 8'(rnd()) & 8'h1f;
      m_sent = codes[k];
      m_toh = (k == 7) ? 16'h0e0f : 16'(rnd() % 3600);
      m_hb = (k == 6) ? 16'h0e0f : 16'(rnd() % 3600);
      m_vl = rnd();
      cmd = {8'h40, m_flags, m_sent, m_toh[15:8], m_toh[7:0], m_hb[15:8], m_hb[7:0], m_vl[31:24], m_vl[23:16],
        m_vl[15:8], m_vl[7:0]};
      send();
      exp_cfg();
      chk_rpt("cfg set");
      chk_val("flags", m_flags, cfg_flags_r);
      chk_val("sentence", m_sent, cfg_hb_sentence_r);
      chk_val("offset", m_toh, cfg_toh_offset_r);
      chk_val("interval", m_hb, cfg_hb_interval_r);
      chk_val("label", m_vl, cfg_vehicle_label_r);
    end
    cmd[3] = 8'h0e;
    cmd[4] = 8'h10;
    k = bad_cnt;
    send();
    chk_val("refused", k + 1, bad_cnt);
    chk_val("offset", m_toh, cfg_toh_offset_r);
    chk_rpt("cfg refused");
    // Times back in range, but a sentence code the output does not know.
    cmd[3] = 8'h00;
    cmd[2] = 8'h01;
    send();
    chk_val("refused", k + 2, bad_cnt);
    chk_val("sentence", m_sent, cfg_hb_sentence_r);
    chk_rpt("sentence refused");
    cmd = {8'h26};
    send();
    exp_cfg();
    for (k = 0; k < 11; k++)
      chk_val("nv image", exp[k], nv_img[8 * k +: 8]);
    exp.delete();
    exp_img({192'h0, 8'h26, 32'h0}, 5);
    chk_rpt("save");
    close_out();
  end
endmodule // tb_top
